// File: rtl/dmr_cfg.sv
// Mode-register configuration, latency pipeline and calibration readout of the memory device.
// Behaviour
// - DLL off in self-refresh, back on exit.
// - Writes need DLL only with write termination.
// - Driver impedance from MR1 bits one, five.
// - Write termination applies even without nominal termination.
// - Reads and writes delayed by additive latency.
// - Additive latency decoded from MR1 bits three, four.
// - Read latency is additive plus CAS latency.
// - Write latency is additive plus CAS write latency.
// - MR1 bit twelve disconnects data outputs.
// - Bank address two selects MR2 write.
// - Write leveling uses nominal termination only.
// - Partial array setting reported for self-refresh.
// - Bank address three selects MR3 write.
// - Readout mode routes reads to selected location.
// - Only reads and mode-register writes allowed while readout mode on.
// - Auto-precharge skipped in readout mode.
// - Location zero returns alternating pattern.
// - Bank address one selects MR1 write.
`timescale 1ns/100ps
module dmr_cfg
	import dmr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic ck_clk,
	input wire dmr_pins_type pins,
	input wire logic odt,
	input wire logic [3:0] cas_latency,
	output logic [15:0] dq_o,
	output logic dq_oe_n,
	output logic exec_rd,
	output logic exec_wr,
	output logic exec_ap,
	output logic [2:0] term_code,
	output logic term_is_wr,
	output logic [1:0] drive_sel,
	output dmr_stat_type stat_o,
	output logic stat_upd
);
	logic link_rst_n;
	logic [15:0] mr1_r;
	logic [15:0] mr2_r;
	logic [15:0] mr3_r;
	logic cke_prev_r;
	logic in_sr_r;
	logic dll_on_r;
	logic mpr_viol_r;
	logic wr_fault_r;
	dmr_op_type pipe_r [DMR_PIPE_D];
	dmr_op_type new_op;
	dmr_op_type exec_tap;
	dmr_op_type rd_tap;
	dmr_op_type wr_tap;
	dmr_cmd_type cmd;
	logic [5:0] al_cur;
	logic [5:0] rl_cur;
	logic [5:0] wl_cur;
	logic [5:0] cl_ext;
	logic [3:0] rbeat_r;
	logic rburst_r;
	logic [7:0] rpat_r;
	logic [3:0] wbeat_r;
	logic wburst_r;
	dmr_stat_type stat_cur;
	dmr_stat_type snap_r;
	logic req_tg_r;
	logic busy_r;
	logic ack_s;
	logic req_s;
	logic seen_r;

	// Decodes the command pins, taking CKE history into account for self-refresh entry.
	function automatic dmr_cmd_type cmd_decode(input dmr_pins_type p, input logic cke_prev);
		dmr_cmd_type c;
		c = CMD_NOP;
		if (!p.cs_n && cke_prev) begin
			if (!p.ras_n && !p.cas_n && !p.we_n && p.cke) begin
				c = CMD_MRS;
			end else if (!p.ras_n && !p.cas_n && p.we_n && !p.cke) begin
				c = CMD_SRE;
			end else if (p.ras_n && !p.cas_n && p.we_n) begin
				c = CMD_RD;
			end else if (p.ras_n && !p.cas_n && !p.we_n) begin
				c = CMD_WR;
			end else if (!(p.ras_n && p.cas_n && p.we_n)) begin
				c = CMD_OTHER;
			end
		end
		return c;
	endfunction

	// Picks the pipeline entry that has waited the given number of cycles.
	function automatic dmr_op_type op_tap(input logic [5:0] lat);
		dmr_op_type t;
		t = new_op;
		if (lat != 6'h00) begin
			t = pipe_r[lat[4:0] - 5'h01];
		end
		return t;
	endfunction

	// Brings the system reset into the link clock domain.
	dmr_sync u_rst_sync (
		.clk(ck_clk),
		.rst_n(1'b1),
		.d(rst_n),
		.q(link_rst_n)
	);

	// Command decode and latency arithmetic.
	always_comb begin
		cmd = cmd_decode(pins, cke_prev_r);
		cl_ext = {2'h0, cas_latency};
		al_cur = 6'h00;
		if (mr1_r[MR1_AL_LO +: 2] == DMR_AL_CLM1) begin
			al_cur = cl_ext - 6'h01;
		end else if (mr1_r[MR1_AL_LO +: 2] == DMR_AL_CLM2) begin
			al_cur = cl_ext - 6'h02;
		end
		rl_cur = al_cur + cl_ext;
		wl_cur = al_cur + mr2_r[MR2_CWL_LO +: 3] + DMR_CWL_BASE;
		new_op.rd = (cmd == CMD_RD);
		new_op.wr = (cmd == CMD_WR) && !mr3_r[MR3_MPR];
		new_op.ap = pins.addr[10] && !mr3_r[MR3_MPR];
		new_op.calibration_readout_register = mr3_r[MR3_MPR];
		new_op.loc = mr3_r[MR3_LOC_LO +: 2];
		exec_tap = op_tap(al_cur);
		rd_tap = op_tap(rl_cur);
		wr_tap = op_tap(wl_cur);
	end

	// Mode registers take the address opcode on each decoded MRS to bank address one, two or three.
	always_ff @(posedge ck_clk) begin
		if (!link_rst_n) begin
			mr1_r <= DMR_MR_RST;
			mr2_r <= DMR_MR_RST;
			mr3_r <= DMR_MR_RST;
		end else if (cmd == CMD_MRS) begin
			if (pins.ba == DMR_BA_MR1) begin
				mr1_r <= pins.addr;
			end else if (pins.ba == DMR_BA_MR2) begin
				mr2_r <= pins.addr;
			end else if (pins.ba == DMR_BA_MR3) begin
				mr3_r <= pins.addr;
			end
		end
	end

	// Self-refresh tracking and the DLL state that follows it.
	always_ff @(posedge ck_clk) begin
		if (!link_rst_n) begin
			cke_prev_r <= 1'b0;
			in_sr_r <= 1'b0;
			dll_on_r <= 1'b0;
		end else begin
			cke_prev_r <= pins.cke;
			if (cmd == CMD_SRE) begin
				in_sr_r <= 1'b1;
			end else if (in_sr_r && pins.cke) begin
				in_sr_r <= 1'b0;
			end
			if (cmd == CMD_SRE) begin
				dll_on_r <= 1'b0;
			end else if (in_sr_r && !pins.cke) begin
				dll_on_r <= 1'b0;
			end else begin
				dll_on_r <= !mr1_r[MR1_DLL_OFF];
			end
		end
	end

	// Sticky faults: forbidden commands in readout mode and writes that need the DLL.
	always_ff @(posedge ck_clk) begin
		if (!link_rst_n) begin
			mpr_viol_r <= 1'b0;
			wr_fault_r <= 1'b0;
		end else begin
			if (mr3_r[MR3_MPR] && (cmd == CMD_WR || cmd == CMD_SRE || cmd == CMD_OTHER)) begin
				mpr_viol_r <= 1'b1;
			end
			if (wr_tap.wr && mr2_r[MR2_RTTWR_LO +: 2] != 2'h0 && !dll_on_r) begin
				wr_fault_r <= 1'b1;
			end
		end
	end

	// Latency pipeline shifts every accepted read and write one cycle per clock.
	always_ff @(posedge ck_clk) begin
		if (!link_rst_n) begin
			for (int i = 0; i < DMR_PIPE_D; i++) begin
				pipe_r[i] <= '0;
			end
		end else begin
			pipe_r[0] <= new_op;
			for (int i = 1; i < DMR_PIPE_D; i++) begin
				pipe_r[i] <= pipe_r[i - 1];
			end
		end
	end

	// Internal execution strobes after the additive latency; readout reads touch no array.
	always_ff @(posedge ck_clk) begin
		if (!link_rst_n) begin
			exec_rd <= 1'b0;
			exec_wr <= 1'b0;
			exec_ap <= 1'b0;
		end else begin
			exec_rd <= exec_tap.rd && !exec_tap.calibration_readout_register;
			exec_wr <= exec_tap.wr;
			exec_ap <= (exec_tap.rd || exec_tap.wr) && exec_tap.ap;
		end
	end

	// Readout burst starts at read latency and drives the selected pattern on every lane.
	always_ff @(posedge ck_clk) begin
		if (!link_rst_n) begin
			rburst_r <= 1'b0;
			rbeat_r <= 4'h0;
			rpat_r <= DMR_PAT_RFU;
			dq_o <= 16'h0000;
			dq_oe_n <= 1'b1;
		end else begin
			if (rd_tap.rd && rd_tap.calibration_readout_register) begin
				rburst_r <= 1'b1;
				rbeat_r <= 4'h0;
				rpat_r <= (rd_tap.loc == DMR_LOC_PAT) ? DMR_PAT_FIXED : DMR_PAT_RFU;
			end else if (rburst_r) begin
				rbeat_r <= rbeat_r + 4'h1;
				rburst_r <= (rbeat_r != DMR_BURST_LAST);
			end
			dq_o <= {DMR_DQ_W{rburst_r && rpat_r[rbeat_r[2:0]]}};
			dq_oe_n <= !rburst_r || mr1_r[MR1_QOFF];
		end
	end

	// Write burst window at write latency, used to pick the termination value.
	always_ff @(posedge ck_clk) begin
		if (!link_rst_n) begin
			wburst_r <= 1'b0;
			wbeat_r <= 4'h0;
		end else if (wr_tap.wr) begin
			wburst_r <= 1'b1;
			wbeat_r <= 4'h0;
		end else if (wburst_r) begin
			wbeat_r <= wbeat_r + 4'h1;
			wburst_r <= (wbeat_r != DMR_BURST_LAST);
		end
	end

	// Termination and driver selection; write value wins during writes unless leveling.
	always_ff @(posedge ck_clk) begin
		if (!link_rst_n) begin
			term_code <= 3'h0;
			term_is_wr <= 1'b0;
			drive_sel <= 2'h0;
		end else begin
			drive_sel <= {mr1_r[MR1_DIC_HI], mr1_r[MR1_DIC_LO]};
			if (!odt || !dll_on_r) begin
				term_code <= 3'h0;
				term_is_wr <= 1'b0;
			end else if (wburst_r && !mr1_r[MR1_WLVL] && mr2_r[MR2_RTTWR_LO +: 2] != 2'h0) begin
				term_code <= {1'b0, mr2_r[MR2_RTTWR_LO +: 2]};
				term_is_wr <= 1'b1;
			end else begin
				term_code <= {mr1_r[MR1_RTT_B2], mr1_r[MR1_RTT_B1], mr1_r[MR1_RTT_B0]};
				term_is_wr <= 1'b0;
			end
		end
	end

	// Status snapshot gathered from the mode registers and the block state.
	always_comb begin
		stat_cur.dll_on = dll_on_r;
		stat_cur.self_refresh = in_sr_r;
		stat_cur.mpr_on = mr3_r[MR3_MPR];
		stat_cur.mpr_loc = mr3_r[MR3_LOC_LO +: 2];
		stat_cur.drive_sel = {mr1_r[MR1_DIC_HI], mr1_r[MR1_DIC_LO]};
		stat_cur.rtt_nom = {mr1_r[MR1_RTT_B2], mr1_r[MR1_RTT_B1], mr1_r[MR1_RTT_B0]};
		stat_cur.rtt_wr = mr2_r[MR2_RTTWR_LO +: 2];
		stat_cur.al = al_cur;
		stat_cur.rl = rl_cur;
		stat_cur.wl = wl_cur;
		stat_cur.out_off = mr1_r[MR1_QOFF];
		stat_cur.wr_level = mr1_r[MR1_WLVL];
		stat_cur.partial_array_selfrefresh = mr2_r[MR2_PARTIAL_ARRAY_SELFREFRESH_LO +: 3];
		stat_cur.automatic_selfrefresh = mr2_r[MR2_ASR];
		stat_cur.selfrefresh_temperature_bit = mr2_r[MR2_SRT];
		stat_cur.mpr_viol = mpr_viol_r;
		stat_cur.wr_dll_fault = wr_fault_r;
	end

	// Link side of the toggle handshake; the snapshot holds still while a transfer is open.
	always_ff @(posedge ck_clk) begin
		if (!link_rst_n) begin
			snap_r <= '0;
			req_tg_r <= 1'b0;
			busy_r <= 1'b0;
		end else if (!busy_r && stat_cur != snap_r) begin
			snap_r <= stat_cur;
			req_tg_r <= !req_tg_r;
			busy_r <= 1'b1;
		end else if (busy_r && ack_s == req_tg_r) begin
			busy_r <= 1'b0;
		end
	end

	// Request toggle into the system domain.
	dmr_sync u_req_sync (
		.clk(sys_clk),
		.rst_n(rst_n),
		.d(req_tg_r),
		.q(req_s)
	);

	// Acknowledge toggle back into the link domain.
	dmr_sync u_ack_sync (
		.clk(ck_clk),
		.rst_n(link_rst_n),
		.d(seen_r),
		.q(ack_s)
	);

	// System side loads the stable snapshot when the request toggle changes.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			seen_r <= 1'b0;
			stat_o <= '0;
			stat_upd <= 1'b0;
		end else begin
			stat_upd <= (req_s != seen_r);
			if (req_s != seen_r) begin
				seen_r <= req_s;
				stat_o <= snap_r;
			end
		end
	end

	// Checks on the link-domain behaviour.
	default clocking dmr_cb @(posedge ck_clk); endclocking
	default disable iff (!link_rst_n);

	dll_selfref_a: assert property ((cmd == CMD_SRE) |=> !dll_on_r ##0 in_sr_r)
		else $error("DLL still on after self-refresh entry");
	dll_exit_a: assert property ((in_sr_r && pins.cke && !mr1_r[MR1_DLL_OFF]) |=> ##1 dll_on_r)
		else $error("DLL not back on after self-refresh exit");
	al_zero_a: assert property ((cmd == CMD_RD && al_cur == 6'h00 && !mr3_r[MR3_MPR]) |=> exec_rd)
		else $error("Read without additive latency not executed next cycle");
	al_decode_a: assert property ((mr1_r[MR1_AL_LO +: 2] == DMR_AL_CLM2) |-> (al_cur + 6'h02 == cl_ext))
		else $error("Additive latency not CL minus two");
	rl_sum_a: assert property (stat_cur.rl == stat_cur.al + cl_ext)
		else $error("Read latency differs from sum");
	qoff_out_a: assert property (mr1_r[MR1_QOFF] && $past(mr1_r[MR1_QOFF]) |-> dq_oe_n)
		else $error("Outputs driven while disabled");
	mr2_write_a: assert property ((cmd == CMD_MRS && pins.ba == DMR_BA_MR2) |=> mr2_r == $past(pins.addr))
		else $error("MR2 opcode not latched");
	mr3_write_a: assert property ((cmd == CMD_MRS && pins.ba == DMR_BA_MR3) |=> mr3_r == $past(pins.addr))
		else $error("MR3 opcode not latched");
	mr1_write_a: assert property ((cmd == CMD_MRS && pins.ba == DMR_BA_MR1) |=> mr1_r == $past(pins.addr))
		else $error("MR1 opcode not latched");
	mpr_noap_a: assert property ((exec_tap.calibration_readout_register && exec_tap.rd) |=> !exec_ap && !exec_rd)
		else $error("Readout read touched array or precharged");
	mpr_viol_a: assert property ((mr3_r[MR3_MPR] && cmd == CMD_OTHER) |=> mpr_viol_r)
		else $error("Forbidden command in readout mode not flagged");
	mpr_pattern_a: assert property ((rburst_r && rpat_r == DMR_PAT_FIXED && !mr1_r[MR1_QOFF])
		|=> dq_o[0] == $past(rbeat_r[0]) && !dq_oe_n)
		else $error("Readout pattern bit wrong");
	wlvl_term_a: assert property ((mr1_r[MR1_WLVL] && odt) |=> !term_is_wr)
		else $error("Write termination used in write leveling");

	mpr_burst_c: cover property (rd_tap.rd && rd_tap.calibration_readout_register ##1 rburst_r [*8]);
	selfref_c: cover property ((cmd == CMD_SRE) ##[1:20] (in_sr_r && pins.cke));
	wr_term_c: cover property (term_is_wr);
	al_read_c: cover property ((cmd == CMD_RD && al_cur != 6'h00) ##[1:30] exec_rd);
endmodule

// File: rtl/dmr_pkg.sv
// Package with the constants, command codes and carrier types of the mode-register block.
package dmr_pkg;

	// Bus widths and the depth of the latency pipeline.
	localparam int DMR_ADDR_W = 16;
	localparam int DMR_BA_W = 3;
	localparam int DMR_DQ_W = 16;
	localparam int DMR_LAT_W = 6;
	localparam int DMR_PIPE_D = 32;
	localparam logic [3:0] DMR_BURST_LAST = 4'h7;

	// Bank addresses that select a mode register on an MRS.
	localparam logic [2:0] DMR_BA_MR1 = 3'h1;
	localparam logic [2:0] DMR_BA_MR2 = 3'h2;
	localparam logic [2:0] DMR_BA_MR3 = 3'h3;

	// Field positions in MR1.
	localparam int MR1_DLL_OFF = 0;
	localparam int MR1_DIC_LO = 1;
	localparam int MR1_DIC_HI = 5;
	localparam int MR1_RTT_B0 = 2;
	localparam int MR1_RTT_B1 = 6;
	localparam int MR1_RTT_B2 = 9;
	localparam int MR1_AL_LO = 3;
	localparam int MR1_WLVL = 7;
	localparam int MR1_QOFF = 12;

	// Field positions in MR2.
	localparam int MR2_PARTIAL_ARRAY_SELFREFRESH_LO = 0;
	localparam int MR2_CWL_LO = 3;
	localparam int MR2_ASR = 6;
	localparam int MR2_SRT = 7;
	localparam int MR2_RTTWR_LO = 9;

	// Field positions in MR3.
	localparam int MR3_LOC_LO = 0;
	localparam int MR3_MPR = 2;

	// Field encodings and reset values.
	localparam logic [1:0] DMR_AL_OFF = 2'h0;
	localparam logic [1:0] DMR_AL_CLM1 = 2'h1;
	localparam logic [1:0] DMR_AL_CLM2 = 2'h2;
	localparam logic [5:0] DMR_CWL_BASE = 6'h05;
	localparam logic [1:0] DMR_LOC_PAT = 2'h0;
	localparam logic [7:0] DMR_PAT_FIXED = 8'hAA;
	localparam logic [7:0] DMR_PAT_RFU = 8'h00;
	localparam logic [15:0] DMR_MR_RST = 16'h0000;

	// Commands recognised on the command pins.
	typedef enum logic [2:0] {
		CMD_NOP,
		CMD_MRS,
		CMD_RD,
		CMD_WR,
		CMD_SRE,
		CMD_OTHER
	} dmr_cmd_type;

	// Command pins as sampled on the link clock.
	typedef struct packed {
		logic cke;
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [2:0] ba;
		logic [15:0] addr;
	} dmr_pins_type;

	// One accepted read or write on its way through the latency pipeline.
	typedef struct packed {
		logic rd;
		logic wr;
		logic ap;
		logic calibration_readout_register;
		logic [1:0] loc;
	} dmr_op_type;

	// Configuration and status snapshot passed to the system clock.
	typedef struct packed {
		logic dll_on;
		logic self_refresh;
		logic mpr_on;
		logic [1:0] mpr_loc;
		logic [1:0] drive_sel;
		logic [2:0] rtt_nom;
		logic [1:0] rtt_wr;
		logic [5:0] al;
		logic [5:0] rl;
		logic [5:0] wl;
		logic out_off;
		logic wr_level;
		logic [2:0] partial_array_selfrefresh;
		logic automatic_selfrefresh;
		logic selfrefresh_temperature_bit;
		logic mpr_viol;
		logic wr_dll_fault;
	} dmr_stat_type;

endpackage

// File: rtl/dmr_sync.sv
// Two-flop synchroniser for one level signal.
`timescale 1ns/100ps
module dmr_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic meta_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// File: verif/dmr_cfg_tb.sv
// Testbench that drives the mode-register block through the controller model and checks its outputs.
`timescale 1ns/100ps
module dmr_cfg_tb
	import dmr_pkg::*;
;
	logic sys_clk = 1'b0;
	logic ck_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] cas_latency = 4'h6;
	dmr_pins_type pins;
	logic odt;
	logic [15:0] dq_o;
	logic dq_oe_n;
	logic exec_rd;
	logic exec_wr;
	logic exec_ap;
	logic [2:0] term_code;
	logic term_is_wr;
	logic [1:0] drive_sel;
	dmr_stat_type stat_o;
	logic stat_upd;
	int upd_cnt = 0;
	int num_errors = 0;
	int compares = 0;

	// System clock and an unrelated link clock.
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		#17;
		forever #62.5 ck_clk = ~ck_clk;
	end

	dmr_cfg dut (.sys_clk(sys_clk), .rst_n(rst_n), .ck_clk(ck_clk), .pins(pins), .odt(odt),
		.cas_latency(cas_latency), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .exec_rd(exec_rd),
		.exec_wr(exec_wr), .exec_ap(exec_ap), .term_code(term_code), .term_is_wr(term_is_wr),
		.drive_sel(drive_sel), .stat_o(stat_o), .stat_upd(stat_upd));
	dmr_ctrl_model model (.ck_clk(ck_clk), .pins(pins), .odt(odt));

	// Compares one value and reports a mismatch.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic finish_test();
		if (num_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Counts status update pulses seen in the system domain.
	always @(posedge sys_clk) begin
		if (stat_upd === 1'b1) upd_cnt++;
	end

	// Lets the status snapshot finish its crossing before it is compared.
	task automatic settle();
		repeat (12) @(posedge ck_clk);
		#1;
	endtask

	// Counts link edges until an execute pulse, with a bound.
	task automatic wait_ex(input logic wr, output int n);
		n = 0;
		#1;
		while ((wr ? exec_wr : exec_rd) !== 1'b1 && n < 40) begin
			@(posedge ck_clk);
			#1;
			n++;
		end
		if ((wr ? exec_wr : exec_rd) !== 1'b1) begin
			num_errors++;
			finish_test();
		end
	endtask

	// Values right after reset: outputs idle, DLL on, readout off.
	task automatic t_reset();
		check(dq_oe_n, 1'b1);
		check({exec_rd, exec_wr, drive_sel}, 16'h0000);
		check(stat_o.mpr_on, 1'b0);
		check(stat_o.dll_on, 1'b1);
		check(upd_cnt != 0, 1'b1);
	endtask

	// Every additive latency code against read delay, drive select and latencies.
	task automatic t_latency();
		int n;
		int al;
		logic [1:0] c;
		model.mrs(DMR_BA_MR2, 16'h0010);
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			al = (c == 2'h1) ? cas_latency - 1 : (c == 2'h2) ? cas_latency - 2 : 0;
			model.mrs(DMR_BA_MR1, {10'h000, c[1], c, 1'b0, c[0], 1'b0});
			model.issue(4'h5, 1'b1, 3'h2, 16'h0400);
			wait_ex(1'b0, n);
			check(16'(n), 16'(al));
			check(exec_ap, 1'b1);
			check(drive_sel, c);
			settle();
			check(stat_o.rl, 16'(al + cas_latency));
			check(stat_o.wl, 16'(al + DMR_CWL_BASE + 2));
		end
		model.issue(4'h4, 1'b1, 3'h1, 16'h0000);
		wait_ex(1'b1, n);
		check(16'(n), 16'h0000);
	endtask

	// Readout bursts: fixed pattern, reserved location, and output disable.
	task automatic t_mpr();
		int rl;
		logic oe;
		rl = cas_latency;
		for (int p = 0; p < 3; p++) begin
			model.mrs(DMR_BA_MR1, (p == 2) ? 16'h1000 : 16'h0000);
			model.mrs(DMR_BA_MR3, (p == 1) ? 16'h0005 : 16'h0004);
			model.issue(4'h5, 1'b1, 3'h7, 16'h0400);
			for (int k = 1; k <= rl + 10; k++) begin
				@(posedge ck_clk);
				#1;
				oe = (p == 2) || k < rl + 1 || k > rl + 8;
				check(dq_oe_n, oe);
				if (!oe) check(dq_o, (p == 0 && k[0] == rl[0]) ? 16'hFFFF : 16'h0000);
				check({exec_rd, exec_ap}, 16'h0000);
			end
			check(stat_o.mpr_on, 1'b1);
			model.mrs(DMR_BA_MR3, 16'h0000);
		end
		model.mrs(DMR_BA_MR3, 16'h0004);
		model.issue(4'h4, 1'b1, 3'h0, 16'h0000);
		repeat (12) begin
			@(posedge ck_clk);
			#1;
			check(exec_wr, 1'b0);
		end
		check(stat_o.mpr_viol, 1'b1);
		model.mrs(DMR_BA_MR3, 16'h0000);
		settle();
		check(stat_o.mpr_on, 1'b0);
	endtask

	// Write-time termination without nominal value, then write leveling, then DLL off.
	task automatic t_term();
		logic [3:0] seen;
		model.mrs(DMR_BA_MR2, 16'h0200);
		for (int p = 0; p < 2; p++) begin
			model.mrs(DMR_BA_MR1, (p == 1) ? 16'h0084 : 16'h0000);
			model.set_odt(1'b1);
			model.issue(4'h4, 1'b1, 3'h0, 16'h0000);
			seen = 4'h0;
			repeat (20) begin
				@(posedge ck_clk);
				#1;
				if (term_is_wr === 1'b1 || term_code !== 3'h0) seen = {term_is_wr, term_code};
			end
			check(seen, (p == 1) ? 16'h0001 : 16'h0009);
			model.set_odt(1'b0);
		end
		model.mrs(DMR_BA_MR1, 16'h0001);
		model.issue(4'h4, 1'b1, 3'h0, 16'h0000);
		settle();
		check(stat_o.wr_dll_fault, 1'b1);
		model.mrs(DMR_BA_MR2, 16'h0000);
		model.mrs(DMR_BA_MR1, 16'h0000);
	endtask

	// Self-refresh entry turns the DLL off and exit turns it back on.
	task automatic t_selfref();
		model.mrs(DMR_BA_MR2, 16'h00C3);
		model.issue(4'h1, 1'b0, 3'h0, 16'h0000);
		settle();
		check({stat_o.self_refresh, stat_o.dll_on}, 16'h0002);
		check(stat_o.partial_array_selfrefresh, 16'h0003);
		check({stat_o.automatic_selfrefresh, stat_o.selfrefresh_temperature_bit}, 16'h0003);
		model.issue(4'hF, 1'b1, 3'h0, 16'h0000);
		settle();
		check({stat_o.self_refresh, stat_o.dll_on}, 16'h0001);
	endtask

	// Reset, then each scenario in turn.
	initial begin
		repeat (20) @(posedge sys_clk);
		repeat (4) @(posedge ck_clk);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ck_clk);
		settle();
		t_reset();
		t_latency();
		t_mpr();
		t_term();
		t_selfref();
		finish_test();
	end
endmodule

// File: verif/dmr_ctrl_model.sv
// Memory controller model that drives the command pins of the device on the link clock.
`timescale 1ns/100ps
module dmr_ctrl_model
	import dmr_pkg::*;
(
	input wire logic ck_clk,
	output dmr_pins_type pins,
	output logic odt
);
	// Deselected bus with clock enable high; no activate is ever sent, so banks stay idle.
	initial begin
		pins = {1'b1, 4'hF, 3'h0, 16'h0000};
		odt = 1'b0;
	end

	// Drives one command for a cycle, then deselects and inverts the released lines.
	task automatic issue(input logic [3:0] cmd, input logic cke, input logic [2:0] ba,
		input logic [15:0] a);
		@(posedge ck_clk);
		pins <= {cke, cmd, ba, a};
		@(posedge ck_clk);
		pins.cs_n <= 1'b1;
		pins.ba <= ~ba;
		pins.addr <= ~a;
	endtask

	// Writes a mode register with its reserved opcode bits forced to zero.
	task automatic mrs(input logic [2:0] ba, input logic [15:0] op);
		logic [15:0] m;
		m = (ba == DMR_BA_MR1) ? 16'h1AFF : (ba == DMR_BA_MR2) ? 16'h06DF : 16'h0007;
		issue(4'h0, 1'b1, ba, op & m);
	endtask

	// Changes the termination request just after a link edge.
	task automatic set_odt(input logic v);
		@(posedge ck_clk);
		odt <= v;
	endtask
endmodule
